// ===== design/pnme_regs.v
// next-page capture, indirect device access and power-down pulse logic
//
// Local design decision: the AHB-Lite interface to the registers.
`include "pnme_map.vh"
`default_nettype none
module pnme_regs #(
  parameter [27:0] CLK_KHZ = `PNME_CLK_KHZ,
  parameter [27:0] TX_CYC0 = `PNME_MS2CYC(`PNME_TX_MS0, CLK_KHZ),
  parameter [27:0] TX_CYC1 = `PNME_MS2CYC(`PNME_TX_MS1, CLK_KHZ),
  parameter [27:0] TX_CYC2 = `PNME_MS2CYC(`PNME_TX_MS2, CLK_KHZ),
  parameter [27:0] TX_CYC3 = `PNME_MS2CYC(`PNME_TX_MS3, CLK_KHZ),
  parameter [27:0] RX_CYC0 = `PNME_MS2CYC(`PNME_RX_MS0, CLK_KHZ),
  parameter [27:0] RX_CYC1 = `PNME_MS2CYC(`PNME_RX_MS1, CLK_KHZ),
  parameter [27:0] RX_CYC2 = `PNME_MS2CYC(`PNME_RX_MS2, CLK_KHZ),
  parameter [27:0] RX_CYC3 = `PNME_MS2CYC(`PNME_RX_MS3, CLK_KHZ)
) (
  input wire sys_clk,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout_ff,
  output reg [31:0] hrdata_ff,
  output reg hresp_ff,
  input wire rxPageValid,
  input wire [15:0] rxPageWord,
  input wire nlpRxPin,
  input wire energyOnPin,
  input wire otherPortPowerDown,
  input wire [15:0] mmdRdata,
  output reg mmdWrStb_ff,
  output reg mmdRdStb_ff,
  output reg [4:0] mmdDevSel_ff,
  output reg [15:0] mmdRegAddr_ff,
  output reg [15:0] mmdWdata_ff,
  output reg nlpTxPulse_ff,
  output reg powerDown_ff
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function hit;
    input [5:0] wordAddr;
    input [5:0] idx;
    begin
      hit = (wordAddr == idx);
    end
  endfunction
  function [27:0] txCycles;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: txCycles = TX_CYC0;
        2'h1: txCycles = TX_CYC1;
        2'h2: txCycles = TX_CYC2;
        default: txCycles = TX_CYC3;
      endcase
    end
  endfunction
  function [27:0] rxCycles;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: rxCycles = RX_CYC0;
        2'h1: rxCycles = RX_CYC1;
        2'h2: rxCycles = RX_CYC2;
        default: rxCycles = RX_CYC3;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [15:0] npWord_ff;
  reg [1:0] mmdFn_ff;
  reg [15:0] cfg_ff;
  reg edpdEnable_ff;
  reg wrPend_ff;
  reg [5:0] wrIdx_ff;
  reg rdWait_ff;
  wire [5:0] aIdx;
  wire addrTaken;
  wire wrNow;
  wire dataMode;
  wire srstNow;
  reg [31:0] rdMux;
  wire txAllowed;
  assign aIdx = haddr[7:2];
  assign addrTaken = hsel & htrans[1] & hready & hreadyout_ff;
  assign wrNow = wrPend_ff;
  assign dataMode = (mmdFn_ff == `PNME_FN_DATA);
  assign srstNow = wrNow & hit(wrIdx_ff, `PNME_IDX_SRST) & hwdata[`PNME_SRST_BIT];
  // ----------------------------------------------------------------
  // pin synchronisers, second and third stage must agree
  // ----------------------------------------------------------------
  reg [2:0] nlpSync_ff;
  reg [2:0] eonSync_ff;
  reg nlpLvl_ff;
  reg eonLvl_ff;
  reg nlpSeen_ff;
  always @(posedge sys_clk) begin
    if (reset) begin
      nlpSync_ff <= 3'h0;
      eonSync_ff <= 3'h7;
      nlpLvl_ff <= 1'b0;
      eonLvl_ff <= 1'b1;
      nlpSeen_ff <= 1'b0;
    end else begin
      nlpSync_ff <= {nlpSync_ff[1:0], nlpRxPin};
      eonSync_ff <= {eonSync_ff[1:0], energyOnPin};
      if (nlpSync_ff[1] == nlpSync_ff[2]) begin
        nlpLvl_ff <= nlpSync_ff[2];
      end
      if (eonSync_ff[1] == eonSync_ff[2]) begin
        eonLvl_ff <= eonSync_ff[2];
      end
      nlpSeen_ff <= (nlpSync_ff[1] == nlpSync_ff[2]) & nlpSync_ff[2] & ~nlpLvl_ff;
    end
  end

  // ----------------------------------------------------------------
  // read mux, reserved bits read zero
  // ----------------------------------------------------------------
  always @* begin
    rdMux = 32'h00000000;
    if (hit(aIdx, `PNME_IDX_NP_RX)) begin
      rdMux[15:0] = npWord_ff;
    end else if (hit(aIdx, `PNME_IDX_MMD_CTL)) begin
      rdMux[`PNME_FN_HI:`PNME_FN_LO] = mmdFn_ff;
      rdMux[`PNME_DEV_HI:0] = mmdDevSel_ff;
    end else if (hit(aIdx, `PNME_IDX_MMD_AD)) begin
      rdMux[15:0] = mmdRegAddr_ff;
    end else if (hit(aIdx, `PNME_IDX_PD_CFG)) begin
      rdMux[15:0] = cfg_ff;
    end else if (hit(aIdx, `PNME_IDX_MODE)) begin
      rdMux[`PNME_MODE_ENERGY_DETECT_POWERDOWN] = edpdEnable_ff;
      rdMux[`PNME_MODE_EON] = eonLvl_ff;
    end else if (hit(aIdx, `PNME_IDX_STAT)) begin
      rdMux[`PNME_STAT_PD] = powerDown_ff;
      rdMux[`PNME_STAT_TXOK] = txAllowed;
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // data-mode reads of the indirect register take one wait state so
  // the device space sees a strobe before its data is sampled
  always @(posedge sys_clk) begin
    if (reset) begin
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h00000000;
      hresp_ff <= 1'b0;
      wrPend_ff <= 1'b0;
      wrIdx_ff <= 6'h00;
      rdWait_ff <= 1'b0;
      mmdRdStb_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
      mmdRdStb_ff <= 1'b0;
      wrPend_ff <= addrTaken & hwrite;
      if (addrTaken) begin
        wrIdx_ff <= aIdx;
      end
      if (rdWait_ff) begin
        rdWait_ff <= 1'b0;
        hreadyout_ff <= 1'b1;
        hrdata_ff <= {16'h0000, mmdRdata};
      end else if (addrTaken & ~hwrite) begin
        if (hit(aIdx, `PNME_IDX_MMD_AD) & dataMode) begin
          rdWait_ff <= 1'b1;
          hreadyout_ff <= 1'b0;
          mmdRdStb_ff <= 1'b1;
          hrdata_ff <= 32'h00000000;
        end else if (hit(aIdx, `PNME_IDX_MMD_AD) & ~(mmdFn_ff == `PNME_FN_ADDR)) begin
          hrdata_ff <= 32'h00000000;
        end else begin
          hrdata_ff <= rdMux;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // received next page
  // ----------------------------------------------------------------
  // the ack bit is forced high by reception itself, the partner's
  // own bit 14 is not passed through
  always @(posedge sys_clk) begin
    if (reset) begin
      npWord_ff <= `PNME_RST_WORD;
    end else if (rxPageValid) begin
      npWord_ff[`PNME_NP_NEXT] <= rxPageWord[`PNME_NP_NEXT];
      npWord_ff[`PNME_NP_ACK] <= 1'b1;
      npWord_ff[`PNME_NP_MSG] <= rxPageWord[`PNME_NP_MSG];
      npWord_ff[`PNME_NP_ACK2] <= rxPageWord[`PNME_NP_ACK2];
      npWord_ff[`PNME_NP_TOG] <= rxPageWord[`PNME_NP_TOG];
      npWord_ff[`PNME_NP_CODE_HI:0] <= rxPageWord[`PNME_NP_CODE_HI:0];
    end
  end

  // ----------------------------------------------------------------
  // indirect device access
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      mmdFn_ff <= `PNME_RST_FN;
      mmdDevSel_ff <= `PNME_RST_DEV;
      mmdRegAddr_ff <= `PNME_RST_WORD;
      mmdWdata_ff <= `PNME_RST_WORD;
      mmdWrStb_ff <= 1'b0;
    end else begin
      mmdWrStb_ff <= 1'b0;
      if (wrNow & hit(wrIdx_ff, `PNME_IDX_MMD_CTL)) begin
        mmdFn_ff <= hwdata[`PNME_FN_HI:`PNME_FN_LO];
        mmdDevSel_ff <= hwdata[`PNME_DEV_HI:0];
      end
      if (wrNow & hit(wrIdx_ff, `PNME_IDX_MMD_AD)) begin
        if (mmdFn_ff == `PNME_FN_ADDR) begin
          mmdRegAddr_ff <= hwdata[15:0];
        end else if (dataMode) begin
          mmdWdata_ff <= hwdata[15:0];
          mmdWrStb_ff <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration, mode and soft reset
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      cfg_ff <= `PNME_RST_WORD;
      edpdEnable_ff <= 1'b0;
    end else begin
      if (srstNow) begin
        cfg_ff <= `PNME_RST_WORD;
      end else if (wrNow & hit(wrIdx_ff, `PNME_IDX_PD_CFG)) begin
        cfg_ff <= {hwdata[15:10], 6'h00, hwdata[3], 3'h0};
      end
      if (wrNow & hit(wrIdx_ff, `PNME_IDX_MODE)) begin
        edpdEnable_ff <= hwdata[`PNME_MODE_ENERGY_DETECT_POWERDOWN];
      end
    end
  end

  // ----------------------------------------------------------------
  // power-down state machine
  // ----------------------------------------------------------------
  localparam ST_ACTIVE = 1'b0;
  localparam ST_PD = 1'b1;
  reg state_ff;
  reg nxt_state;
  reg armed_ff;
  reg firstPulse_ff;
  reg nxt_firstPulse;
  wire txExp;
  wire gapExp;
  wire gapBusy;
  wire wake;
  wire txEnable;
  wire singleWake;

  assign txEnable = cfg_ff[`PNME_CFG_TXEN];
  assign singleWake = cfg_ff[`PNME_CFG_SINGLE];
  // shared pulse generator needs both ports idle unless independent
  assign txAllowed = powerDown_ff & (cfg_ff[`PNME_CFG_INDEP] | otherPortPowerDown);
  assign wake = nlpSeen_ff & (singleWake | (firstPulse_ff & gapBusy));

  always @* begin
    nxt_state = state_ff;
    nxt_firstPulse = firstPulse_ff;
    case (state_ff)
      ST_ACTIVE: begin
        nxt_firstPulse = 1'b0;
        if (edpdEnable_ff & armed_ff & ~eonLvl_ff) begin
          nxt_state = ST_PD;
        end
      end
      ST_PD: begin
        if (~edpdEnable_ff | wake) begin
          nxt_state = ST_ACTIVE;
          nxt_firstPulse = 1'b0;
        end else if (nlpSeen_ff) begin
          nxt_firstPulse = 1'b1;
        end else if (gapExp) begin
          nxt_firstPulse = 1'b0;
        end
      end
      default: begin
        nxt_state = ST_ACTIVE;
        nxt_firstPulse = 1'b0;
      end
    endcase
  end

  // after entering power-down the link must show energy again before re-entry,
  // otherwise a quiet cable would bounce straight back
  always @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= ST_ACTIVE;
      powerDown_ff <= 1'b0;
      armed_ff <= 1'b0;
      firstPulse_ff <= 1'b0;
      nlpTxPulse_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      powerDown_ff <= (nxt_state == ST_PD);
      firstPulse_ff <= nxt_firstPulse;
      if (state_ff == ST_ACTIVE & nxt_state == ST_PD) begin
        armed_ff <= 1'b0;
      end else if (eonLvl_ff) begin
        armed_ff <= 1'b1;
      end
      nlpTxPulse_ff <= txExp & txEnable & txAllowed;
    end
  end

  // ----------------------------------------------------------------
  // interval timers
  // ----------------------------------------------------------------
  wire txRun;
  wire txBusy;
  assign txRun = txEnable & txAllowed;

  pnme_nlp_timer txTimer (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(txRun & ~txBusy),
    .stop(~txRun),
    .loadVal(txCycles(cfg_ff[`PNME_CFG_TXI_HI:`PNME_CFG_TXI_LO])),
    .expired_ff(txExp),
    .busy(txBusy)
  );

  pnme_nlp_timer gapTimer (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(nlpSeen_ff & (state_ff == ST_PD)),
    .stop(state_ff == ST_ACTIVE),
    .loadVal(rxCycles(cfg_ff[`PNME_CFG_RXI_HI:`PNME_CFG_RXI_LO])),
    .expired_ff(gapExp),
    .busy(gapBusy)
  );
endmodule
`default_nettype wire

// ===== design/pnme_map.vh
// register map, field positions, reset values and timing counts
`ifndef PNME_MAP_VH
`define PNME_MAP_VH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PNME_IDX_NP_RX 6'h08
`define PNME_IDX_MMD_CTL 6'h0d
`define PNME_IDX_MMD_AD 6'h0e
`define PNME_IDX_PD_CFG 6'h10
`define PNME_IDX_MODE 6'h11
`define PNME_IDX_SRST 6'h18
`define PNME_IDX_STAT 6'h19
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PNME_NP_NEXT 15
`define PNME_NP_ACK 14
`define PNME_NP_MSG 13
`define PNME_NP_ACK2 12
`define PNME_NP_TOG 11
`define PNME_NP_CODE_HI 10
`define PNME_FN_HI 15
`define PNME_FN_LO 14
`define PNME_DEV_HI 4
`define PNME_FN_ADDR 2'h0
`define PNME_FN_DATA 2'h1
`define PNME_CFG_TXEN 15
`define PNME_CFG_TXI_HI 14
`define PNME_CFG_TXI_LO 13
`define PNME_CFG_SINGLE 12
`define PNME_CFG_RXI_HI 11
`define PNME_CFG_RXI_LO 10
`define PNME_CFG_INDEP 3
`define PNME_MODE_ENERGY_DETECT_POWERDOWN 13
`define PNME_MODE_EON 1
`define PNME_SRST_BIT 0
`define PNME_STAT_PD 0
`define PNME_STAT_TXOK 1
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PNME_RST_WORD 16'h0000
`define PNME_RST_FN 2'h0
`define PNME_RST_DEV 5'h00
// ----------------------------------------------------------------
// timing: intervals in ms, cycles at the clock rate in kHz
// ----------------------------------------------------------------
`define PNME_CLK_KHZ 125000
`define PNME_MS2CYC(ms, khz) ((ms) * (khz))
`define PNME_TX_MS0 1000
`define PNME_TX_MS1 768
`define PNME_TX_MS2 512
`define PNME_TX_MS3 256
`define PNME_RX_MS0 64
`define PNME_RX_MS1 256
`define PNME_RX_MS2 512
`define PNME_RX_MS3 1000
`endif

// ===== design/pnme_nlp_timer.v
// one-shot countdown timer with expiry pulse
`default_nettype none
module pnme_nlp_timer (
  input wire sys_clk,
  input wire reset,
  input wire start,
  input wire stop,
  input wire [27:0] loadVal,
  output reg expired_ff,
  output wire busy
);
  reg [27:0] cnt_ff;
  reg [27:0] nxt_cnt;
  reg nxt_expired;

  assign busy = (cnt_ff != 28'h0000000);

  always @* begin
    nxt_cnt = cnt_ff;
    nxt_expired = 1'b0;
    if (stop) begin
      nxt_cnt = 28'h0000000;
    end else if (start) begin
      nxt_cnt = loadVal;
    end else if (busy) begin
      nxt_cnt = cnt_ff - 28'h0000001;
      nxt_expired = (cnt_ff == 28'h0000001);
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      cnt_ff <= 28'h0000000;
      expired_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      expired_ff <= nxt_expired;
    end
  end
endmodule
`default_nettype wire

// ===== bench/pnme_regs_sva.sv
// checker bound to the register bank top
`default_nettype none
module pnme_regs_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout_ff,
  input wire logic [31:0] hrdata_ff,
  input wire logic mmdWrStb_ff,
  input wire logic mmdRdStb_ff,
  input wire logic [4:0] mmdDevSel_ff,
  input wire logic [15:0] mmdRegAddr_ff,
  input wire logic [15:0] mmdWdata_ff,
  input wire logic nlpTxPulse_ff,
  input wire logic powerDown_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // shadow of the write data phase and function code
  // ------------------------------------------------
  logic take;
  logic wrPend_ff;
  logic [5:0] idx_ff;
  logic [1:0] fn_ff;
  logic dataRd;
  assign take = hsel & htrans[1] & hreadyout_ff;
  assign dataRd = take & ~hwrite & (haddr[7:2] == 6'h0e) & (fn_ff == 2'h1);
  always @(posedge sys_clk) begin
    if (reset) begin
      wrPend_ff <= 1'b0;
      idx_ff <= 6'h00;
      fn_ff <= 2'h0;
    end else begin
      wrPend_ff <= take & hwrite;
      if (take) idx_ff <= haddr[7:2];
      if (wrPend_ff && idx_ff == 6'h0d) fn_ff <= hwdata[15:14];
    end
  end
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence s_dataRd;
    dataRd;
  endsequence
  sequence s_waitOne;
    !hreadyout_ff && mmdRdStb_ff ##1 hreadyout_ff && !mmdRdStb_ff;
  endsequence
  a_rd_wait: assert property (s_dataRd |=> s_waitOne)
    else $error("data read without one wait state");
  a_rd_strobe: assert property (mmdRdStb_ff |-> $past(dataRd))
    else $error("device read strobe without data-mode read");
  a_zero_wait: assert property (take && !dataRd |=> hreadyout_ff)
    else $error("unexpected wait state");
  a_wr_strobe: assert property (mmdWrStb_ff |-> fn_ff == 2'h1 &&
    $past(wrPend_ff && idx_ff == 6'h0e) && mmdWdata_ff == $past(hwdata[15:0]))
    else $error("device write strobe wrong");
  a_addr_keep: assert property (!$stable(mmdRegAddr_ff) && !$past(reset) |->
    $past(wrPend_ff && idx_ff == 6'h0e && fn_ff == 2'h0)
    && mmdRegAddr_ff == $past(hwdata[15:0])) else $error("target address changed");
  a_dev_write: assert property (!$stable(mmdDevSel_ff) && !$past(reset) |->
    $past(wrPend_ff && idx_ff == 6'h0d) && mmdDevSel_ff == $past(hwdata[4:0]))
    else $error("device select changed");
  a_tx_gate: assert property (nlpTxPulse_ff |-> $past(powerDown_ff))
    else $error("link pulse outside power-down");
  a_upper_zero: assert property (hreadyout_ff && $past(take && !hwrite) |->
    hrdata_ff[31:16] == 16'h0000) else $error("upper read bits set");
endmodule
bind pnme_regs pnme_regs_sva pnme_regs_sva_inst (.sys_clk(sys_clk), .reset(reset),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hreadyout_ff(hreadyout_ff), .hrdata_ff(hrdata_ff), .mmdWrStb_ff(mmdWrStb_ff),
  .mmdRdStb_ff(mmdRdStb_ff), .mmdDevSel_ff(mmdDevSel_ff), .mmdRegAddr_ff(mmdRegAddr_ff),
  .mmdWdata_ff(mmdWdata_ff), .nlpTxPulse_ff(nlpTxPulse_ff), .powerDown_ff(powerDown_ff));
`default_nettype wire

// ===== bench/pnme_partner.sv
// link partner and device-space model
`default_nettype none
module pnme_partner (
  input wire logic sys_clk,
  input wire logic mmdWrStb,
  input wire logic mmdRdStb,
  input wire logic [4:0] mmdDevSel,
  input wire logic [15:0] mmdRegAddr,
  input wire logic [15:0] mmdWdata,
  output logic [15:0] mmdRdata,
  output logic rxPageValid,
  output logic [15:0] rxPageWord,
  output logic nlpRxPin,
  output logic energyOnPin,
  output logic [7:0] wrCnt,
  output logic [31:0] lastWr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rdVal;
  assign rdVal = {mmdDevSel[3:0], mmdRegAddr[11:0]} ^ 16'h5a5a;
  // idle read bus shows the inverse so stale data cannot pass
  assign mmdRdata = mmdRdStb ? rdVal : ~rdVal;
  initial begin
    rxPageValid = 1'b0;
    rxPageWord = 16'h0000;
    nlpRxPin = 1'b0;
    energyOnPin = 1'b0;
    wrCnt = 8'h00;
    lastWr = 32'h0;
  end
  always @(posedge sys_clk) begin
    if (mmdWrStb) begin
      wrCnt <= wrCnt + 8'h01;
      lastWr <= {mmdDevSel[3:0], mmdRegAddr[11:0], mmdWdata};
    end
  end
  task sendPage(input logic [15:0] w);
    @(posedge sys_clk);
    rxPageValid <= 1'b1;
    rxPageWord <= w;
    @(posedge sys_clk);
    rxPageValid <= 1'b0;
    rxPageWord <= ~w;
  endtask
  task sendNlp;
    @(posedge sys_clk);
    nlpRxPin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    nlpRxPin <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ===== bench/pnme_regs_bench.sv
// self-checking bench for the register bank
`default_nettype none
module pnme_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TX[4] = '{1000, 768, 512, 256};
  localparam int RX[4] = '{64, 256, 512, 1000};
  localparam logic [31:0] RSTA[4] = '{32'h20, 32'h34, 32'h38, 32'h44};
  logic sys_clk, reset, hsel, hwrite, hreadyout_ff, hresp_ff, rxPageValid;
  logic nlpRxPin, energyOnPin, otherPortPowerDown, mmdWrStb_ff, mmdRdStb_ff;
  logic nlpTxPulse_ff, powerDown_ff;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] mmdDevSel_ff;
  logic [7:0] wrCnt;
  logic [15:0] rxPageWord, mmdRdata, mmdRegAddr_ff, mmdWdata_ff;
  logic [31:0] haddr, hwdata, hrdata_ff, rd, lastWr;
  int bad_count = 0;
  int checks_done = 0;
  int c, k;
  // one cycle per millisecond keeps the interval ratios and a short run
  pnme_regs #(.CLK_KHZ(28'd1))
  pnme_regs_inst (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout_ff), .hreadyout_ff(hreadyout_ff), .hrdata_ff(hrdata_ff),
    .hresp_ff(hresp_ff), .rxPageValid(rxPageValid), .rxPageWord(rxPageWord),
    .nlpRxPin(nlpRxPin), .energyOnPin(energyOnPin), .otherPortPowerDown(otherPortPowerDown),
    .mmdRdata(mmdRdata), .mmdWrStb_ff(mmdWrStb_ff), .mmdRdStb_ff(mmdRdStb_ff),
    .mmdDevSel_ff(mmdDevSel_ff), .mmdRegAddr_ff(mmdRegAddr_ff), .mmdWdata_ff(mmdWdata_ff),
    .nlpTxPulse_ff(nlpTxPulse_ff), .powerDown_ff(powerDown_ff));
  pnme_partner pnme_partner_inst (.sys_clk(sys_clk), .mmdWrStb(mmdWrStb_ff),
    .mmdRdStb(mmdRdStb_ff), .mmdDevSel(mmdDevSel_ff), .mmdRegAddr(mmdRegAddr_ff),
    .mmdWdata(mmdWdata_ff), .mmdRdata(mmdRdata), .rxPageValid(rxPageValid),
    .rxPageWord(rxPageWord), .nlpRxPin(nlpRxPin), .energyOnPin(energyOnPin),
    .wrCnt(wrCnt), .lastWr(lastWr));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------
  task final_report;
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task waitFor(input int sel, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((sel == 0 ? hreadyout_ff : sel == 1 ? powerDown_ff : nlpTxPulse_ff) !== v
      && n < lim);
    if (n >= lim) begin
      bad_count++;
      final_report;
    end
  endtask
  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    waitFor(0, 1'b1, 20, c);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitFor(0, 1'b1, 20, c);
    rd = hrdata_ff;
    check(hresp_ff, 32'h0);
  endtask
  task rdChk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task enterPd;
    energyOnPin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    energyOnPin <= 1'b0;
    xfer(1'b1, 32'h44, 32'h2000);
    waitFor(1, 1'b1, 50, c);
  endtask
  task countPulses(output int n);
    n = 0;
    repeat (250) begin
      @(posedge sys_clk);
      if (nlpTxPulse_ff === 1'b1) n++;
    end
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    otherPortPowerDown = 1'b0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (RSTA[i]) rdChk(RSTA[i], 32'h0);
    rdChk(32'h40, 32'h0);
    pnme_partner_inst.sendPage(16'ha5a5);
    rdChk(32'h20, 32'he5a5);
    pnme_partner_inst.sendPage(16'h0923);
    rdChk(32'h20, 32'h4923);
    xfer(1'b1, 32'h34, 32'h0007);
    xfer(1'b1, 32'h38, 32'h1234);
    rdChk(32'h38, 32'h1234);
    check(mmdDevSel_ff, 32'h7);
    xfer(1'b1, 32'h34, 32'h7fe3);
    rdChk(32'h34, 32'h4003);
    rdChk(32'h38, 32'h686e);
    xfer(1'b1, 32'h38, 32'hbeef);
    // the partner takes the strobe one edge after it rises
    repeat (2) @(posedge sys_clk);
    check(lastWr, 32'h3234beef);
    check(mmdRegAddr_ff, 32'h1234);
    xfer(1'b1, 32'h34, 32'h8003);
    rdChk(32'h38, 32'h0);
    xfer(1'b1, 32'h38, 32'h5555);
    repeat (2) @(posedge sys_clk);
    check(wrCnt, 32'h1);
    xfer(1'b1, 32'h7c, 32'hffff);
    rdChk(32'h7c, 32'h0);
    xfer(1'b1, 32'h40, 32'hffff);
    rdChk(32'h40, 32'hfc08);
    xfer(1'b1, 32'h60, 32'h1);
    rdChk(32'h40, 32'h0);
    for (k = 0; k < 4; k++) begin
      // enable, independent and single wake set together
      xfer(1'b1, 32'h40, 32'h9008 | (k << 13));
      enterPd;
      waitFor(2, 1'b1, 1100, c);
      waitFor(2, 1'b1, 1100, c);
      check(c, TX[k] + 1);
      pnme_partner_inst.sendNlp;
      waitFor(1, 1'b0, 20, c);
    end
    xfer(1'b1, 32'h40, 32'h8000);
    enterPd;
    countPulses(c);
    check(c, 0);
    otherPortPowerDown <= 1'b1;
    waitFor(2, 1'b1, 1100, c);
    xfer(1'b1, 32'h40, 32'h0008);
    countPulses(c);
    check(c, 0);
    xfer(1'b1, 32'h44, 32'h0);
    waitFor(1, 1'b0, 20, c);
    energyOnPin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    energyOnPin <= 1'b0;
    repeat (20) @(posedge sys_clk);
    check(powerDown_ff, 1'b0);
    for (k = 0; k < 4; k++) begin
      xfer(1'b1, 32'h40, k << 10);
      enterPd;
      pnme_partner_inst.sendNlp;
      repeat (RX[k] + 15) @(posedge sys_clk);
      pnme_partner_inst.sendNlp;
      check(powerDown_ff, 1'b1);
      // second pulse of a pair lands just inside the gap
      repeat (RX[k] - 20) @(posedge sys_clk);
      pnme_partner_inst.sendNlp;
      waitFor(1, 1'b0, 20, c);
    end
    final_report;
  end
endmodule
`default_nettype wire
